// ===== logic/rx_doppler_fifo_cfg.svh
`ifndef RX_DOPPLER_FIFO_CFG_SVH
`define RX_DOPPLER_FIFO_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADDR_W     18
`define PTR_W      19
`define DEPTH      262144
`define DLY_W      18
`define RATE_W     22
`define DIV_W      40
`define PCT_W      8
`define MS_W       16

// ----------------------------------------------------------------
// limits, reset values and counts
// ----------------------------------------------------------------
`define DELAY_MIN  18'h00004
`define DELAY_MAX  18'h1fffe
`define DELAY_RST  18'h00400
`define RATE_RST   22'h0f4240
`define MS_PER_SEC 40'h00000003e8
`define PCT_SCALE  40'h0000000064
`define PCT_SAT    8'hff
`define MS_SAT     16'hffff
`define SETTLE_CYC 3'h4

`endif

// ===== logic/rx_doppler_fifo_pkg.sv
`default_nettype none
`include "rx_doppler_fifo_cfg.svh"

package rx_doppler_fifo_pkg;

  // ----------------------------------------------------------------
  // read clock sources, read-side states, configuration carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_RX  = 2'h0,
    SEL_MOD = 2'h1,
    SEL_EXT = 2'h2
  } clk_sel_t;

  typedef enum logic [3:0] {
    ST_CALC  = 4'h1,
    ST_FILL  = 4'h2,
    ST_RUN   = 4'h4,
    ST_FLUSH = 4'h8
  } rd_state_t;

  typedef struct packed {
    clk_sel_t             sel;
    logic                 by_ms;
    logic [`DLY_W-1:0]    value;
    logic [`RATE_W-1:0]   rate;
  } fifo_cfg_t;

endpackage : rx_doppler_fifo_pkg

`default_nettype wire

// ===== logic/ptr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// gray-coded pointer crossing: only one bit moves per step, so the
// far side never sees a torn value while the pointer counts by one
module ptr_sync #(
  parameter int W = 19
) (
  input  wire logic         src_clk_in,
  input  wire logic         dst_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] bin_in,
  output logic      [W-1:0] bin_out
);

  logic [W-1:0] gray_r;
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // ----------------------------------------------------------------
  // source side encode
  // ----------------------------------------------------------------
  always_ff @(posedge src_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      gray_r <= '0;
    else
      gray_r <= bin_in ^ (bin_in >> 1);
  end

  // ----------------------------------------------------------------
  // destination side two-stage capture and decode
  // ----------------------------------------------------------------
  always_ff @(posedge dst_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= gray_r;
      s2_r <= s1_r;
    end
  end

  for (genvar i = 0; i < W; i++)
  begin : g_dec
    assign bin_out[i] = ^s2_r[W-1:i];
  end

endmodule : ptr_sync

`default_nettype wire

// ===== logic/seq_div.sv
`timescale 1ns/1ps
`default_nettype none

// restoring divider, one quotient bit per cycle; den_in must hold
// steady while busy, a trade of latency for a small footprint
module seq_div #(
  parameter int W = 40
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] num_in,
  input  wire logic [W-1:0] den_in,
  output logic      [W-1:0] quot_out,
  output logic              busy_out,
  output logic              done_out
);

  localparam int CW = $clog2(W + 1);

  logic [W-1:0]  q_r;
  logic [W-1:0]  r_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic          done_r;
  wire logic [W:0]   r_sh  = {r_r, q_r[W-1]};
  wire logic         fits  = r_sh >= {1'b0, den_in};
  wire logic [W:0]   r_sub = r_sh - {1'b0, den_in};
  wire logic [W-1:0] r_new = fits ? r_sub[W-1:0] : r_sh[W-1:0];

  // ----------------------------------------------------------------
  // shift-subtract loop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      q_r    <= '0;
      r_r    <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (start_in)
    begin
      q_r    <= num_in;
      r_r    <= '0;
      cnt_r  <= CW'(W);
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end
    else if (busy_r)
    begin
      q_r    <= {q_r[W-2:0], fits};
      r_r    <= r_new;
      cnt_r  <= cnt_r - 1'b1;
      busy_r <= cnt_r != CW'(1);
      done_r <= cnt_r == CW'(1);
    end
    else
      done_r <= 1'b0;
  end

  assign quot_out = q_r;
  assign busy_out = busy_r;
  assign done_out = done_r;

endmodule : seq_div

`default_nettype wire

// ===== logic/rx_doppler_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_doppler_fifo_cfg.svh"

module rx_doppler_fifo
  import rx_doppler_fifo_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               nrst_in,
  input  wire logic               rx_clk_in,
  input  wire logic               rx_data_in,
  input  wire logic               mod_clk_in,
  input  wire logic               ext_clk_in,
  input  wire fifo_cfg_t          cfg_in,
  input  wire logic               apply_in,
  input  wire logic               recentre_in,
  input  wire logic               flag_clear_in,
  output logic                    rd_clk_out,
  output logic                    rd_data_out,
  output logic                    active_out,
  output logic                    recentred_out,
  output logic [`PCT_W-1:0]       fill_pct_out,
  output logic signed [`PCT_W:0]  fill_remote_out,
  output logic [`DLY_W-1:0]       delay_bits_out,
  output logic [`MS_W-1:0]        delay_ms_out
);

  // ----------------------------------------------------------------
  // storage and link-side state
  // ----------------------------------------------------------------
  logic                 store_mem [0:`DEPTH-1];
  logic [`PTR_W-1:0]    wr_ptr_r;
  logic                 byp_bit_r;
  logic                 req_s1_r;
  logic                 req_s2_r;
  logic                 req_seen_r;
  logic                 ack_lnk_r;

  // ----------------------------------------------------------------
  // system-side state
  // ----------------------------------------------------------------
  rd_state_t            state_r;
  rd_state_t            state_nxt;
  fifo_cfg_t            cfg_r;
  logic [`DLY_W-1:0]    delay_bits_r;
  logic [`MS_W-1:0]     delay_ms_r;
  logic [`PTR_W-1:0]    rd_ptr_r;
  logic [`PTR_W-1:0]    rd_ptr_nxt;
  logic [`PTR_W-1:0]    flush_tgt_r;
  logic [`PTR_W-1:0]    flush_tgt_nxt;
  logic                 flush_req_r;
  logic                 flush_req_nxt;
  logic [2:0]           settle_r;
  logic [2:0]           settle_nxt;
  logic                 calc_pend_r;
  logic                 cent_pend_r;
  logic                 conv_start_r;
  logic                 pct_start_r;
  logic                 flag_r;
  logic                 rd_bit_r;
  logic                 data_r;
  logic                 clk_r;
  logic                 active_r;
  logic [`PCT_W-1:0]    pct_r;
  logic signed [`PCT_W:0] remote_r;
  logic                 ack_s1_r;
  logic                 ack_s2_r;
  logic                 byp_s1_r;
  logic                 byp_s2_r;
  logic [2:0]           ck_s1_r;
  logic [2:0]           ck_s2_r;
  logic [2:0]           ck_s3_r;
  logic [`PTR_W-1:0]    wr_sync;
  logic [`DIV_W-1:0]    conv_q;
  logic                 conv_done;
  logic [`DIV_W-1:0]    pct_q;
  logic                 pct_busy;
  logic                 pct_done;

  // ----------------------------------------------------------------
  // link side: write on the recovered clock, honour flush requests
  // ----------------------------------------------------------------
  wire logic flush_hit = req_s2_r ^ req_seen_r;
  wire logic [`PTR_W-1:0] wr_ptr_nxt =
    flush_hit ? flush_tgt_r : wr_ptr_r + 1'b1;

  // the target is held steady by the system side until acknowledged
  always_ff @(posedge rx_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_r   <= '0;
      byp_bit_r  <= 1'b0;
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
      ack_lnk_r  <= 1'b0;
    end
    else
    begin
      wr_ptr_r   <= wr_ptr_nxt;
      byp_bit_r  <= rx_data_in;
      req_s1_r   <= flush_req_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_s2_r;
      // ack one edge late, so the gray copy already holds the jump
      ack_lnk_r  <= req_seen_r;
    end
  end

  // the bit arriving on a flush edge is dropped with the flushed half
  always_ff @(posedge rx_clk_in)
  begin
    if (!flush_hit)
      store_mem[wr_ptr_r[`ADDR_W-1:0]] <= rx_data_in;
  end

  ptr_sync #(
    .W          (`PTR_W)
  ) u_wr_sync (
    .src_clk_in (rx_clk_in),
    .dst_clk_in (clock_in),
    .nrst_in    (nrst_in),
    .bin_in     (wr_ptr_r),
    .bin_out    (wr_sync)
  );

  // ----------------------------------------------------------------
  // read clock sampling: each source through three flops, one per lane
  // ----------------------------------------------------------------
  wire logic [2:0] ck_raw = {ext_clk_in, mod_clk_in, rx_clk_in};

  for (genvar i = 0; i < 3; i++)
  begin : g_ck
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        ck_s1_r[i] <= 1'b0;
        ck_s2_r[i] <= 1'b0;
        ck_s3_r[i] <= 1'b0;
      end
      else
      begin
        ck_s1_r[i] <= ck_raw[i];
        ck_s2_r[i] <= ck_s1_r[i];
        ck_s3_r[i] <= ck_s2_r[i];
      end
    end
  end

  // modulator clock is only meaningful at equal rates, software's duty
  wire logic sel_s2 = (cfg_r.sel == SEL_MOD) ? ck_s2_r[1] :
                      (cfg_r.sel == SEL_EXT) ? ck_s2_r[2] :
                      ck_s2_r[0];
  wire logic sel_s3 = (cfg_r.sel == SEL_MOD) ? ck_s3_r[1] :
                      (cfg_r.sel == SEL_EXT) ? ck_s3_r[2] :
                      ck_s3_r[0];
  wire logic rd_fall = sel_s3 & ~sel_s2;
  wire logic byp     = cfg_r.sel == SEL_RX;

  // ----------------------------------------------------------------
  // occupancy decode
  // ----------------------------------------------------------------
  wire logic [`PTR_W-1:0] occ = wr_sync - rd_ptr_r;
  wire logic [`PTR_W-1:0] dly = {1'b0, delay_bits_r};
  wire logic [`PTR_W-1:0] dbl = {delay_bits_r, 1'b0};
  wire logic overrun  = !byp && occ >= dbl;
  wire logic reading  = state_r == ST_RUN && rd_fall && !byp
                        && occ != '0;
  wire logic underrun = reading && occ == `PTR_W'(1);
  wire logic filled   = occ >= dly;
  wire logic ack_done = ack_s2_r == flush_req_r;
  wire logic in_run   = state_r == ST_RUN;
  wire logic flag_set = in_run && (overrun || underrun);
  wire logic go_calc  = calc_pend_r && state_r != ST_FLUSH;
  wire logic go_cent  = cent_pend_r && !go_calc
                        && (state_r == ST_FILL || in_run);

  // ----------------------------------------------------------------
  // delay conversion: ms to bits, or bits to ms, from the data rate
  // ----------------------------------------------------------------
  wire logic [`DIV_W-1:0] conv_num = cfg_r.by_ms ?
    `DIV_W'(cfg_r.value) * `DIV_W'(cfg_r.rate) :
    `DIV_W'(cfg_r.value) * `MS_PER_SEC;
  wire logic [`DIV_W-1:0] conv_den = cfg_r.by_ms ?
    `MS_PER_SEC : `DIV_W'(cfg_r.rate);
  wire logic [`DIV_W-1:0] bits_raw = cfg_r.by_ms ?
    conv_q : `DIV_W'(cfg_r.value);
  wire logic [`DLY_W-1:0] bits_clamp =
    (bits_raw > `DIV_W'(`DELAY_MAX)) ? `DELAY_MAX :
    (bits_raw < `DIV_W'(`DELAY_MIN)) ? `DELAY_MIN :
    bits_raw[`DLY_W-1:0];
  wire logic [`DIV_W-1:0] ms_raw = cfg_r.by_ms ?
    `DIV_W'(cfg_r.value) : conv_q;
  wire logic [`MS_W-1:0]  ms_sat = (|ms_raw[`DIV_W-1:`MS_W]) ?
    `MS_SAT : ms_raw[`MS_W-1:0];

  seq_div #(
    .W        (`DIV_W)
  ) u_conv (
    .clk_in   (clock_in),
    .nrst_in  (nrst_in),
    .start_in (conv_start_r),
    .num_in   (conv_num),
    .den_in   (conv_den),
    .quot_out (conv_q),
    .busy_out (),
    .done_out (conv_done)
  );

  // ----------------------------------------------------------------
  // fill percentage, recomputed back to back
  // ----------------------------------------------------------------
  wire logic [`DIV_W-1:0] pct_num = `DIV_W'(occ) * `PCT_SCALE;
  wire logic [`PCT_W-1:0] pct_sat = (|pct_q[`DIV_W-1:`PCT_W]) ?
    `PCT_SAT : pct_q[`PCT_W-1:0];
  wire logic signed [`PCT_W:0] pct_sgn = $signed({1'b0, pct_r});

  seq_div #(
    .W        (`DIV_W)
  ) u_pct (
    .clk_in   (clock_in),
    .nrst_in  (nrst_in),
    .start_in (pct_start_r),
    .num_in   (pct_num),
    .den_in   (`DIV_W'(delay_bits_r)),
    .quot_out (pct_q),
    .busy_out (pct_busy),
    .done_out (pct_done)
  );

  // ----------------------------------------------------------------
  // read-side sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt     = state_r;
    rd_ptr_nxt    = rd_ptr_r;
    flush_req_nxt = flush_req_r;
    flush_tgt_nxt = flush_tgt_r;
    settle_nxt    = settle_r;
    case (state_r)
      ST_CALC:
        if (conv_done)
        begin
          rd_ptr_nxt = wr_sync;
          state_nxt  = ST_FILL;
        end
      ST_FILL:
        if (go_cent)
          rd_ptr_nxt = wr_sync;
        else if (filled)
          state_nxt = ST_RUN;
      ST_RUN:
        if (go_cent)
        begin
          rd_ptr_nxt = wr_sync;
          state_nxt  = ST_FILL;
        end
        else if (overrun && !go_calc)
        begin
          flush_tgt_nxt = rd_ptr_r + dly;
          flush_req_nxt = ~flush_req_r;
          settle_nxt    = 3'h0;
          state_nxt     = ST_FLUSH;
        end
        else if (reading)
        begin
          rd_ptr_nxt = rd_ptr_r + 1'b1;
          if (underrun)
            state_nxt = ST_FILL;
        end
      ST_FLUSH:
        // wait out the gray pointer so the old level is not seen again
        if (ack_done)
        begin
          // a held command goes straight on, no one-cycle output blip
          if (settle_r == `SETTLE_CYC)
            state_nxt = calc_pend_r ? ST_CALC :
                        cent_pend_r ? ST_FILL : ST_RUN;
          else
            settle_nxt = settle_r + 3'h1;
        end
      default:
        state_nxt = ST_CALC;
    endcase
    if (go_calc)
      state_nxt = ST_CALC;
  end

  // sequencer registers
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r     <= ST_CALC;
      rd_ptr_r    <= '0;
      flush_req_r <= 1'b0;
      flush_tgt_r <= '0;
      settle_r    <= 3'h0;
    end
    else
    begin
      state_r     <= state_nxt;
      rd_ptr_r    <= rd_ptr_nxt;
      flush_req_r <= flush_req_nxt;
      flush_tgt_r <= flush_tgt_nxt;
      settle_r    <= settle_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration, commands and the recentred flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cfg_r        <= '{SEL_RX, 1'b0, `DELAY_RST, `RATE_RST};
      calc_pend_r  <= 1'b1;
      cent_pend_r  <= 1'b0;
      conv_start_r <= 1'b0;
      flag_r       <= 1'b0;
      delay_bits_r <= `DELAY_RST;
      delay_ms_r   <= '0;
    end
    else
    begin
      if (apply_in)
        cfg_r <= cfg_in;
      calc_pend_r  <= apply_in || (calc_pend_r && !go_calc);
      cent_pend_r  <= recentre_in || (cent_pend_r && !go_cent);
      conv_start_r <= go_calc;
      // a set in the same cycle as a clear wins
      flag_r <= flag_set ||
                (flag_r && !flag_clear_in && !apply_in);
      if (conv_done && state_r == ST_CALC)
      begin
        delay_bits_r <= bits_clamp;
        delay_ms_r   <= ms_sat;
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake return and bypass data, both from the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      byp_s1_r <= 1'b0;
      byp_s2_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= ack_lnk_r;
      ack_s2_r <= ack_s1_r;
      byp_s1_r <= byp_bit_r;
      byp_s2_r <= byp_s1_r;
    end
  end

  // store read port, no reset so it can map onto block memory
  always_ff @(posedge clock_in)
  begin
    rd_bit_r <= store_mem[rd_ptr_r[`ADDR_W-1:0]];
  end

  // ----------------------------------------------------------------
  // output stream and reporting
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      data_r      <= 1'b0;
      clk_r       <= 1'b0;
      active_r    <= 1'b0;
      pct_start_r <= 1'b0;
      pct_r       <= '0;
      remote_r    <= '0;
    end
    else
    begin
      clk_r <= sel_s3;
      if (byp && rd_fall)
        data_r <= byp_s2_r;
      else if (reading)
        data_r <= rd_bit_r;
      active_r    <= state_nxt == ST_RUN;
      pct_start_r <= !pct_busy && !pct_start_r;
      if (pct_done)
        pct_r <= pct_sat;
      remote_r <= flag_r ? -pct_sgn : pct_sgn;
    end
  end

  assign rd_clk_out      = clk_r;
  assign rd_data_out     = data_r;
  assign active_out      = active_r;
  assign recentred_out   = flag_r;
  assign fill_pct_out    = pct_r;
  assign fill_remote_out = remote_r;
  assign delay_bits_out  = delay_bits_r;
  assign delay_ms_out    = delay_ms_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_flag_sticky: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    flag_r && !flag_clear_in && !apply_in |=> flag_r)
    else $error("recentred flag dropped without a clear");

  chk_set_wins: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    flag_set |=> flag_r ##1 recentred_out)
    else $error("overrun or underrun did not latch the flag");

  chk_clear_cmd: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (flag_clear_in || apply_in) && !flag_set |=> !recentred_out)
    else $error("flag not cleared by command");

  chk_underrun_fill: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    underrun && !go_cent && !go_calc |=> state_r == ST_FILL
      && rd_ptr_r == $past(wr_sync))
    else $error("underrun did not block output for refill");

  chk_fill_block: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    state_r == ST_FILL && !go_cent |=> $stable(rd_ptr_r)
      && $stable(rd_data_out) || byp)
    else $error("data left the store while refilling");

  chk_overrun_flush: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    in_run && overrun && !go_cent && !go_calc |=> state_r == ST_FLUSH
      && flush_tgt_r == $past(rd_ptr_r) + dly
      && flush_req_r != $past(flush_req_r))
    else $error("overrun did not drop the newer half");

  chk_fill_centre: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    state_r == ST_FILL && filled && !go_cent && !go_calc
      |=> state_r == ST_RUN ##1 active_out)
    else $error("centre fill reached but output stayed blocked");

  chk_delay_range: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    delay_bits_out >= `DELAY_MIN && delay_bits_out <= `DELAY_MAX)
    else $error("delay outside four to 131070 bits");

  chk_remote_neg: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    flag_r && pct_r != '0 |=> fill_remote_out < 0)
    else $error("remote fill not negative while recentred");

  chk_bypass_data: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    byp && rd_fall |=> rd_data_out == $past(byp_s2_r))
    else $error("bypass did not pass the receive bit");

endmodule : rx_doppler_fifo

`default_nettype wire

// ===== verif/demod_src.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// demodulator side: recovered bit clock, bits
// ---------------------------------------------
module demod_src (
  output logic rx_clk_out,
  output logic rx_data_out
);
  // new bit just after each rising edge, held a full period
  initial
  begin
    rx_clk_out  = 1'b0;
    rx_data_out = 1'b0;
    #5;
    forever
    begin
      #32 rx_clk_out = ~rx_clk_out;
      #1 rx_data_out = rx_clk_out ? 1'($urandom) : rx_data_out;
    end
  end
endmodule : demod_src
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import rx_doppler_fifo_pkg::*;;
  // ---------------------------------------------
  // stimulus, notes queue and watcher
  // ---------------------------------------------
  logic              clock_in, nrst_in, rx_clk, rx_data, mod_clk;
  logic              ext_clk, ext_run, apply, recentre, fclr, byp_chk;
  logic [1:0]        rx_hist;
  logic              rd_clk, rd_data, active, recentred;
  logic [7:0]        pct;
  logic signed [8:0] remote;
  logic [17:0]       dbits;
  logic [15:0]       dms;
  fifo_cfg_t         cfg;
  logic [33:0]       notes[$];
  int                failures, checked, cyc, rises, v;
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // modulator clock at a 64 ns period, slightly faster than the 66 ns receive clock
  initial
  begin
    mod_clk = 1'b0;
    forever #32 mod_clk = ~mod_clk;
  end
  // station clock faster than receive, so the store drains
  initial
  begin
    ext_clk = 1'b0;
    forever #20 ext_clk = ext_run & ~ext_clk;
  end
  demod_src src_u (.rx_clk_out(rx_clk), .rx_data_out(rx_data));
  rx_doppler_fifo dut_u (.clock_in, .nrst_in, .rx_clk_in(rx_clk),
    .rx_data_in(rx_data), .mod_clk_in(mod_clk), .ext_clk_in(ext_clk),
    .cfg_in(cfg), .apply_in(apply), .recentre_in(recentre),
    .flag_clear_in(fclr), .rd_clk_out(rd_clk), .rd_data_out(rd_data),
    .active_out(active), .recentred_out(recentred),
    .fill_pct_out(pct), .fill_remote_out(remote),
    .delay_bits_out(dbits), .delay_ms_out(dms));
  task automatic finish_test;
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [33:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc_n
  task automatic hold(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) @(posedge clock_in);
  endtask : hold
  // m picks apply, recentre, flag clear, high for one clock
  task automatic pulse(input logic [2:0] m);
    {apply, recentre, fclr} <= m;
    @(posedge clock_in);
    {apply, recentre, fclr} <= 3'h0;
    cyc_n(3);
  endtask : pulse
  // a note is due when output next starts flowing
  task automatic set(input clk_sel_t s, logic ms, int d, r, bit n,
                     logic [33:0] e);
    cfg <= '{s, ms, d[17:0], r[21:0]};
    if (n) notes.push_back(e);
    pulse(3'h4);
  endtask : set
  task automatic rate(input int e);
    rises = 0;
    cyc_n(640);
    chk(rises >= e - 1 && rises <= e + 1, 1);
  endtask : rate
  always @(posedge rd_clk) rises++;
  always @(posedge active)
    if (notes.size() > 0) chk({dbits, dms}, notes.pop_front());
  // bypass passes the bit taken at the receive edge before last
  always @(posedge rx_clk) rx_hist <= {rx_hist[0], rx_data};
  always @(posedge rd_clk)
    if (byp_chk) chk(rd_data, rx_hist[1]);
  // hang guard, well above the longest sequence
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      finish_test();
    end
  end
  initial
  begin
    {nrst_in, apply, recentre, fclr, ext_run, byp_chk} = '0;
    {failures, checked} = '0;
    cfg = '0;
    cyc = 0;
    void'($urandom(17));
    cyc_n(11);
    chk(dbits, 18'h00400);
    @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3)
    begin
      v = 4 + $urandom % 60;
      set(SEL_EXT, 0, v, 1000000, 1, {v[17:0], 16'h0000});
      hold(active, 3000);
      hold(recentred, 4000);
      chk(recentred, 1);
      cyc_n(1);
      chk(remote[8], 1);
      pulse(3'h1);
      chk(recentred, 0);
    end
    set(SEL_EXT, 1, 2, 4000, 1, {18'h00008, 16'h0002});
    hold(active, 2000);
    set(SEL_EXT, 0, 2, 1000000, 1, {18'h00004, 16'h0000});
    hold(active, 2000);
    set(SEL_EXT, 1, 1000, 1000000, 0, 0);
    cyc_n(60);
    chk(dbits, 18'h1fffe);
    set(SEL_MOD, 0, 8, 1000000, 1, {18'h00008, 16'h0000});
    hold(active, 2000);
    rate(40);
    chk(pct >= 8'h4b && pct <= 8'h7d, 1);
    chk(recentred, 0);
    notes.push_back({18'h00008, 16'h0000});
    pulse(3'h2);
    chk(active, 0);
    hold(active, 2000);
    set(SEL_EXT, 0, 8, 1000000, 0, 0);
    ext_run <= 1'b1;
    hold(recentred, 3000);
    chk(recentred, 1);
    ext_run <= 1'b0;
    set(SEL_RX, 0, 8, 1000000, 0, 0);
    cyc_n(60);
    byp_chk <= 1'b1;
    rate(40);
    chk(notes.size(), 0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
